// ### sccd_pkg.sv
// Purpose: constants for the serial clock counter and start/stop unit
// Assumes: byte addresses on an 8-bit register address port
// Notes:   status layout is shared by the status and interrupt registers
package sccd_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_STATUS   = 8'h28;
    localparam logic [7:0] ADDR_CTRL     = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;

    // status and interrupt bit positions
    localparam int ST_CNT8  = 3;
    localparam int ST_CNT9  = 2;
    localparam int ST_START = 1;
    localparam int ST_BUSY  = 0;
    localparam int ST_W     = 4;

    // control bit positions
    localparam int CTRL_BUS_MODE   = 0;
    localparam int CTRL_THREE_WIRE = 1;
    localparam int CTRL_W          = 2;

    // reset values
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [1:0] CTRL_RESET   = 2'h0;

    // counter values
    localparam int         CNT_W     = 4;
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [3:0] CNT_ONE   = 4'h1;
    localparam logic [3:0] CNT_EIGHT = 4'h8;
    localparam logic [3:0] CNT_NINE  = 4'h9;

endpackage

// ### sccd_counter.sv
// Purpose: shift clock counter with start/stop detection for a serial port
// Assumes: pins are asynchronous; control strobes come from clk logic
// Notes:   counter value itself is hidden; only counts 8 and 9 are shown
//
// How it works
// - a wraparound counter tracks pulses on the selected shift clock pin
// - two-wire mode samples the two-wire pin, three-wire the other pin
// - pin level is observed directly, master or slave alike
// - counter holds still while the serial link is waiting
// - software sees the count only through the eight and nine flags
// - bus mode counts rising edges from zero, nine wraps to one
// - serial I/O mode counts falling edges, nine wraps to one
// - separate count-eight and count-nine flags, any role or direction
// - start and stop detection only works in two-wire bus mode
// - bus activity sets on start, held zero in serial I/O mode
// - bus mode clears counter on resets, clock stop, start, mode switch
// - I/O mode clears counter on resets, clock stop, wait write, switch
// - read-only status: count eight, count nine, start, activity
`timescale 1ns/10ps

module sccd_counter
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // link pins
    input  wire logic              two_wire_clock_pin,
    input  wire logic              three_wire_clock_pin,
    input  wire logic              serial_data_pin,
    // neighbouring serial logic
    input  wire logic              wait_active,
    input  wire logic              clock_stop,
    input  wire logic              ce_reset,
    input  wire logic              wait_ctrl_write,
    output logic                   count_edge,
    // interrupt
    output logic                   irq
);

    // synchroniser chains, stage 0 is read only by stage 1
    logic [2:0] scl_sync;
    logic [2:0] sck_sync;
    logic [2:0] sda_sync;

    // software registers
    logic [sccd_pkg::CTRL_W-1:0] ctrl;
    logic [sccd_pkg::ST_W-1:0]   irq_stat;
    logic [sccd_pkg::ST_W-1:0]   irq_mask;

    // counter and flags
    logic [sccd_pkg::CNT_W-1:0]  count;
    logic                        start_seen_flag;
    logic                        bus_active_flag;

    // next values
    logic [sccd_pkg::CNT_W-1:0]  next_count;
    logic                        next_start_seen;
    logic                        next_bus_active;
    logic [sccd_pkg::ST_W-1:0]   next_irq_stat;
    logic [DATA_W-1:0]           next_rdata;

    // decoded wires
    wire logic bus_mode;
    wire logic three_wire;
    wire logic clk_now;
    wire logic clk_prev;
    wire logic clk_rise;
    wire logic clk_fall;
    wire logic scl_high;
    wire logic start_cond;
    wire logic stop_cond;
    wire logic sel_status;
    wire logic sel_ctrl;
    wire logic sel_irq_stat;
    wire logic sel_irq_mask;
    wire logic ctrl_wr;
    wire logic mode_switch;
    wire logic cnt_clear;
    wire logic hard_clear;
    wire logic count_eight_flag;
    wire logic count_nine_flag;
    wire logic [sccd_pkg::ST_W-1:0] serial_counter_status;
    wire logic [sccd_pkg::ST_W-1:0] events;
    wire logic [sccd_pkg::ST_W-1:0] w1c;

    // bring pins into the clk domain
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_sync <= 3'h0;
            sck_sync <= 3'h0;
            sda_sync <= 3'h0;
        end
        else
        begin
            scl_sync <= {scl_sync[1:0], two_wire_clock_pin};
            sck_sync <= {sck_sync[1:0], three_wire_clock_pin};
            sda_sync <= {sda_sync[1:0], serial_data_pin};
        end
    end

    // mode decode
    assign bus_mode   = ctrl[sccd_pkg::CTRL_BUS_MODE];
    assign three_wire = ctrl[sccd_pkg::CTRL_THREE_WIRE];

    // pick the shift clock pin; bus mode is always two-wire
    assign clk_now  = (!bus_mode && three_wire) ? sck_sync[1]
                                                : scl_sync[1];
    assign clk_prev = (!bus_mode && three_wire) ? sck_sync[2]
                                                : scl_sync[2];

    // edges of the pin level itself, so master and slave look the same
    assign clk_rise = clk_now && !clk_prev;
    assign clk_fall = !clk_now && clk_prev;

    // counting edge depends on mode, frozen while waiting
    assign count_edge = !wait_active
                        && (bus_mode ? clk_rise
                                     : clk_fall);

    // start: data falls while clock high; stop: data rises while high
    assign scl_high   = scl_sync[1] && scl_sync[2];
    assign start_cond = bus_mode && scl_high
                        && sda_sync[2] && !sda_sync[1];
    assign stop_cond  = bus_mode && scl_high
                        && !sda_sync[2] && sda_sync[1];

    // address decode
    assign sel_status   = (reg_addr == sccd_pkg::ADDR_STATUS);
    assign sel_ctrl     = (reg_addr == sccd_pkg::ADDR_CTRL);
    assign sel_irq_stat = (reg_addr == sccd_pkg::ADDR_IRQ_STAT);
    assign sel_irq_mask = (reg_addr == sccd_pkg::ADDR_IRQ_MASK);
    assign ctrl_wr      = reg_wr && sel_ctrl;

    // a write that flips the bus/IO selection counts as a switch
    assign mode_switch = ctrl_wr
                         && (reg_wdata[sccd_pkg::CTRL_BUS_MODE]
                             != bus_mode);

    // clock stop and chip-enable reset wipe the counter, start and activity flags
    assign hard_clear = clock_stop || ce_reset;

    // counter clear sources differ per mode
    assign cnt_clear = hard_clear || mode_switch
                       || (bus_mode ? start_cond
                                    : wait_ctrl_write);

    // wraparound count, clear wins over a coincident edge
    always_comb
    begin
        next_count = count;
        if (cnt_clear)
            next_count = sccd_pkg::CNT_ZERO;
        else if (count_edge)
        begin
            if (count == sccd_pkg::CNT_NINE)
                next_count = sccd_pkg::CNT_ONE;
            else
                next_count = count + sccd_pkg::CNT_ONE;
        end
    end

    // the count itself is never put on the bus
    assign count_eight_flag = (count == sccd_pkg::CNT_EIGHT);
    assign count_nine_flag  = (count == sccd_pkg::CNT_NINE);

    // start flag: set beats the clear at count nine
    always_comb
    begin
        next_start_seen = start_seen_flag;
        if (hard_clear)
            next_start_seen = 1'b0;
        else if (start_cond)
            next_start_seen = 1'b1;
        else if (bus_mode && clk_fall
                 && count == sccd_pkg::CNT_NINE)
            next_start_seen = 1'b0;
    end

    // bus activity follows start and stop, zero outside bus mode
    always_comb
    begin
        next_bus_active = bus_active_flag;
        if (hard_clear || !bus_mode)
            next_bus_active = 1'b0;
        else if (start_cond)
            next_bus_active = 1'b1;
        else if (stop_cond)
            next_bus_active = 1'b0;
    end

    // counter and flags
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count           <= sccd_pkg::CNT_ZERO;
            start_seen_flag <= 1'b0;
            bus_active_flag <= 1'b0;
        end
        else
        begin
            count           <= next_count;
            start_seen_flag <= next_start_seen;
            bus_active_flag <= next_bus_active;
        end
    end

    // read-only status word
    assign serial_counter_status = {count_eight_flag,
                                    count_nine_flag,
                                    start_seen_flag,
                                    bus_active_flag};

    // interrupt events share the status layout; stop sits on bit 0
    assign events[sccd_pkg::ST_CNT8]  = count_edge && !cnt_clear
                                 && next_count == sccd_pkg::CNT_EIGHT;
    assign events[sccd_pkg::ST_CNT9]  = count_edge && !cnt_clear
                                 && next_count == sccd_pkg::CNT_NINE;
    assign events[sccd_pkg::ST_START] = start_cond;
    assign events[sccd_pkg::ST_BUSY]  = stop_cond;

    // write one to clear, a new event in the same cycle survives
    assign w1c = (reg_wr && sel_irq_stat)
                 ? reg_wdata[sccd_pkg::ST_W-1:0]
                 : {sccd_pkg::ST_W{1'b0}};
    assign next_irq_stat = (irq_stat & ~w1c) | events;

    // software registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl     <= sccd_pkg::CTRL_RESET;
            irq_stat <= sccd_pkg::STATUS_RESET;
            irq_mask <= sccd_pkg::STATUS_RESET;
        end
        else
        begin
            if (ctrl_wr)
                ctrl <= reg_wdata[sccd_pkg::CTRL_W-1:0];
            if (reg_wr && sel_irq_mask)
                irq_mask <= reg_wdata[sccd_pkg::ST_W-1:0];
            irq_stat <= next_irq_stat;
        end
    end

    // level interrupt while any unmasked event is pending
    assign irq = |(irq_stat & irq_mask);

    // read mux, unmapped addresses read zero
    always_comb
    begin
        next_rdata = {DATA_W{1'b0}};
        if (reg_rd)
        begin
            if (sel_status)
                next_rdata[sccd_pkg::ST_W-1:0] = serial_counter_status;
            else if (sel_ctrl)
                next_rdata[sccd_pkg::CTRL_W-1:0] = ctrl;
            else if (sel_irq_stat)
                next_rdata[sccd_pkg::ST_W-1:0] = irq_stat;
            else if (sel_irq_mask)
                next_rdata[sccd_pkg::ST_W-1:0] = irq_mask;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= {DATA_W{1'b0}};
        else
            reg_rdata <= next_rdata;
    end

endmodule

// ### sccd_assertions.sv
// Purpose: port checks for the serial clock counter
// Assumes: reads answer in one cycle; pins hold longer than 5 clk
// Notes:   bound into every sccd_counter instance
`timescale 1ns/10ps

module sccd_assertions
(
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins and neighbours
    input wire logic        two_wire_clock_pin,
    input wire logic        three_wire_clock_pin,
    input wire logic        wait_active,
    input wire logic        clock_stop,
    input wire logic        ce_reset,
    input wire logic        count_edge
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // address decode seen from outside
    wire st_rd = reg_rd && reg_addr == sccd_pkg::ADDR_STATUS;
    wire hit   = reg_addr inside {sccd_pkg::ADDR_STATUS,
                                  sccd_pkg::ADDR_CTRL,
                                  sccd_pkg::ADDR_IRQ_STAT,
                                  sccd_pkg::ADDR_IRQ_MASK};

    // clear strobe, then a status read soon after
    sequence s_clr_read;
        (clock_stop || ce_reset) ##[1:3] st_rd;
    endsequence

    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_rdata_upper: assert property (
        reg_rdata[31:4] == 28'h0) else $error("upper read bits set");
    a_unmapped_zero: assert property (
        reg_rd && !hit |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_edge_wait: assert property (
        wait_active |-> !count_edge) else $error("counted during wait");
    a_edge_single: assert property (
        count_edge |=> !count_edge) else $error("count pulse too long");
    a_edge_cause: assert property (
        count_edge |-> two_wire_clock_pin != $past(two_wire_clock_pin, 5)
        || three_wire_clock_pin != $past(three_wire_clock_pin, 5))
        else $error("count without pin edge");
    a_flags_excl: assert property (
        $past(st_rd) |-> !(reg_rdata[3] && reg_rdata[2]))
        else $error("eight and nine flags together");
    a_clear_flags: assert property (
        s_clr_read |=> reg_rdata[3:0] == 4'h0)
        else $error("status not cleared by stop");
endmodule

bind sccd_counter sccd_assertions sccd_assertions_i (
    .clk                  (clk),
    .resetn               (resetn),
    .reg_addr             (reg_addr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .two_wire_clock_pin   (two_wire_clock_pin),
    .three_wire_clock_pin (three_wire_clock_pin),
    .wait_active          (wait_active),
    .clock_stop           (clock_stop),
    .ce_reset             (ce_reset),
    .count_edge           (count_edge));

// ### sccd_station.sv
// Purpose: remote serial station driving the clock and data pins
// Assumes: 80 ns half bit, unrelated in phase to the block clock
// Notes:   clocks stand still between frames
`timescale 1ns/10ps

module sccd_station
(
    // shift clocks and data
    output logic two_wire_clock_pin,
    output logic three_wire_clock_pin,
    output logic serial_data_pin
);
    // idle levels: bus clock low, I/O clock and data high
    initial
    begin
        two_wire_clock_pin = 1'b0;
        three_wire_clock_pin = 1'b1;
        serial_data_pin = 1'b1;
    end

    // external bus clock pulses, rise then fall
    task automatic pulse2(input int n);
        repeat (n)
        begin
            #80 two_wire_clock_pin = 1'b1;
            #80 two_wire_clock_pin = 1'b0;
        end
        #80;
    endtask

    // external I/O clock pulses, fall then rise
    task automatic pulse3(input int n);
        repeat (n)
        begin
            #80 three_wire_clock_pin = 1'b0;
            #80 three_wire_clock_pin = 1'b1;
        end
        #80;
    endtask

    // data moves while the bus clock is high: fall starts, rise stops
    task automatic cond(input logic lvl);
        #80 two_wire_clock_pin = 1'b1;
        #80 serial_data_pin = lvl;
        #80 two_wire_clock_pin = 1'b0;
        #80;
    endtask
endmodule

// ### tb_sccd_counter.sv
// Purpose: directed bench for the serial clock counter
// Assumes: remote station model drives all link pins
// Notes:   status expected values are worked out by hand per step
`timescale 1ns/10ps

module tb_sccd_counter;
    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        p2;
    logic        p3;
    logic        pd;
    logic        wait_active;
    logic        clock_stop;
    logic        ce_reset;
    logic        wait_ctrl_write;
    logic        count_edge;
    logic        irq;
    int          err_count;
    int          num_checks;

    sccd_counter sccd_counter_i (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .two_wire_clock_pin(p2),
        .three_wire_clock_pin(p3), .serial_data_pin(pd),
        .wait_active(wait_active), .clock_stop(clock_stop),
        .ce_reset(ce_reset), .wait_ctrl_write(wait_ctrl_write),
        .count_edge(count_edge), .irq(irq));
    sccd_station sccd_station_i (.two_wire_clock_pin(p2),
        .three_wire_clock_pin(p3), .serial_data_pin(pd));

    // 8 ns clock
    always #4 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle write; result settles just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", reg_rdata, exp);
    endtask

    task automatic st(input logic [3:0] exp);
        rd(sccd_pkg::ADDR_STATUS, {28'h0, exp});
    endtask

    // one-cycle pulse on {ce_reset, clock_stop, wait_ctrl_write}
    task automatic strobe(input logic [2:0] s);
        @(posedge clk);
        ce_reset <= s[2];
        clock_stop <= s[1];
        wait_ctrl_write <= s[0];
        @(posedge clk);
        ce_reset <= 1'b0;
        clock_stop <= 1'b0;
        wait_ctrl_write <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, far beyond the expected 10 us
    initial
    begin
        #400000;
        err_count++;
        final_report();
    end

    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wait_active = 1'b0;
        clock_stop = 1'b0;
        ce_reset = 1'b0;
        wait_ctrl_write = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        st(4'h0);
        rd(8'h3C, 32'h0);
        wr(sccd_pkg::ADDR_STATUS, 32'hF);
        st(4'h0);
        wr(sccd_pkg::ADDR_CTRL, 32'h1);
        wr(sccd_pkg::ADDR_IRQ_MASK, 32'h0);
        sccd_station_i.cond(1'b0);
        st(4'h3);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(sccd_pkg::ADDR_IRQ_MASK, 32'h2);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr(sccd_pkg::ADDR_IRQ_STAT, 32'hF);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        sccd_station_i.pulse2(8);
        st(4'hB);
        rd(sccd_pkg::ADDR_IRQ_STAT, 32'h8);
        @(posedge clk) wait_active <= 1'b1;
        sccd_station_i.pulse2(1);
        st(4'hB);
        @(posedge clk) wait_active <= 1'b0;
        sccd_station_i.pulse2(1);
        st(4'h5);
        sccd_station_i.pulse2(1);
        st(4'h1);
        sccd_station_i.cond(1'b1);
        st(4'h0);
        rd(sccd_pkg::ADDR_IRQ_STAT, 32'hD);
        sccd_station_i.cond(1'b0);
        sccd_station_i.pulse2(8);
        st(4'hB);
        wr(sccd_pkg::ADDR_CTRL, 32'h0);
        st(4'h2);
        wr(sccd_pkg::ADDR_CTRL, 32'h2);
        rd(sccd_pkg::ADDR_CTRL, 32'h2);
        sccd_station_i.pulse3(8);
        st(4'hA);
        sccd_station_i.pulse2(2);
        sccd_station_i.cond(1'b0);
        sccd_station_i.cond(1'b1);
        st(4'hA);
        strobe(3'b001);
        st(4'h2);
        sccd_station_i.pulse3(9);
        st(4'h6);
        strobe(3'b010);
        st(4'h0);
        wr(sccd_pkg::ADDR_CTRL, 32'h1);
        sccd_station_i.pulse2(8);
        st(4'h8);
        strobe(3'b100);
        st(4'h0);
        final_report();
    end
endmodule
